/* File: core/urbs_pkg.sv */
// Purpose: Shared constants and types of the serial receive buffer block
// Assumes: 8-bit register port, 3-bit word address
// Notes:   Entry layout is data[8:0], frame, overrun, parity error
package urbs_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_STAT_A = 3'h1;
  localparam logic [2:0] ADDR_STAT_B = 3'h2;
  localparam logic [2:0] ADDR_STAT_C = 3'h3;
  localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
  localparam logic [2:0] ADDR_BAUD_HI = 3'h5;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int A_RXC = 7;
  localparam int A_FE = 4;
  localparam int A_DOR = 3;
  localparam int A_UPE = 2;
  localparam int A_U2X = 1;
  localparam int B_RXCIE = 7;
  localparam int B_RXEN = 4;
  localparam int B_CSZ2 = 2;
  localparam int B_RXB8 = 1;
  localparam int C_UPM1 = 5;
  localparam int C_UPM0 = 4;
  localparam int C_USBS = 3;
  localparam int C_CSZ_LO = 1;

  // ---------------------------------------------------------------
  // Buffer entry layout
  // ---------------------------------------------------------------
  localparam int ENT_W = 12;
  localparam int ENT_FE = 9;
  localparam int ENT_DOR = 10;
  localparam int ENT_PE = 11;
  localparam int FIFO_DEPTH = 2;

  // ---------------------------------------------------------------
  // Sampling counts
  // ---------------------------------------------------------------
  localparam logic [4:0] SPB_NORM = 5'h10;
  localparam logic [4:0] SPB_DBL = 5'h08;
  localparam logic [4:0] VOTE_NORM = 5'h08;
  localparam logic [4:0] VOTE_DBL = 5'h04;
  localparam logic [4:0] SAMP_FIRST = 5'h01;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] RST_BAUD = 12'h000;
  localparam logic RST_CSZ2 = 1'b0;
  localparam logic [1:0] RST_CSZ_LO = 2'h3;
  localparam logic RST_RXEN = 1'b0;

  // ---------------------------------------------------------------
  // Receiver states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_START = 5'b00010,
    ST_DATA = 5'b00100,
    ST_PARITY = 5'b01000,
    ST_STOP = 5'b10000
  } urbs_state_e;

endpackage

/* File: core/urbs_rx_fifo.sv */
// Purpose: Two-entry first-in first-out store for received characters
// Assumes: Caller never pushes when full nor pops when empty
// Notes:   Flush wins over push and pop in the same cycle
`timescale 1ns/1ns
module urbs_rx_fifo (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Write side
  input wire logic push,
  input wire logic [urbs_pkg::ENT_W-1:0] push_ent,
  // Read side
  input wire logic pop,
  input wire logic flush,
  output logic [urbs_pkg::ENT_W-1:0] head_ent,
  output logic [1:0] count
);

  typedef struct packed {
    logic [urbs_pkg::FIFO_DEPTH-1:0][urbs_pkg::ENT_W-1:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] cnt;
  } urbs_fifo_s;

  urbs_fifo_s q;
  urbs_fifo_s n;
  logic do_push;
  logic do_pop;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Guards keep count honest even if a caller slips
  always_comb begin
    n = q;
    do_push = push & (q.cnt != 2'h2);
    do_pop = pop & (q.cnt != 2'h0);
    for (int i = 0; i < urbs_pkg::FIFO_DEPTH; i++) begin
      if (do_push && (q.wr_ptr == i[0])) begin
        n.mem[i] = push_ent;
      end
    end
    if (do_push) begin
      n.wr_ptr = ~q.wr_ptr;
    end
    if (do_pop) begin
      n.rd_ptr = ~q.rd_ptr;
    end
    n.cnt = 2'(q.cnt + {1'b0, do_push} - {1'b0, do_pop});
    if (flush) begin
      n.wr_ptr = 1'b0;
      n.rd_ptr = 1'b0;
      n.cnt = 2'h0;
    end
  end

  // Storage register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign head_ent = q.mem[q.rd_ptr];
  assign count = q.cnt;

endmodule // urbs_rx_fifo

/* File: core/urbs_receiver.sv */
// Purpose: Asynchronous serial receiver with two-character status buffer
// Assumes: sys_clk 10 MHz; sample tick every (baud+1) clocks
// Notes:   Register reads return data one cycle after the strobe
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ns

// How it works
// - Receive complete flag shows unread data present
// - Receiver disable empties buffer, clears complete flag
// - Interrupt request held while flag and enable
// - Data read advances buffer, status follows
// - Error bits stored with their character
// - Status writes never change error flags
// - Error flags never raise an interrupt
// - Frame error equals inverted first stop bit
// - Only first stop bit examined, count ignored
// - Two entries; overrun on start while full with one character held
// - Overrun cleared on successful transfer into buffer
// - Parity enable bit gates check, odd select
// - Parity error stored only when checking enabled
// - Parity error reads zero with checking off
// - Disable aborts any frame in progress at once
// - Pin override released while receiver disabled
// - Start edge realigns sampling, bits majority filtered
// - Sixteen samples per bit, eight double speed
// - Start voted at 8-10 or 4-6
// - Each bit voted over three centre samples
// - Ninth bit shown in control register, stored
module urbs_receiver (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [urbs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Serial line
  input wire logic rx_pin,
  output logic rx_pin_override,
  // Request
  output logic rx_complete_irq
);

  typedef struct packed {
    urbs_pkg::urbs_state_e state;
    logic sync1;
    logic sync2;
    logic prev_rx;
    logic [11:0] tick_cnt;
    logic [4:0] samp;
    logic [3:0] bit_idx;
    logic vote_a;
    logic vote_b;
    logic [8:0] shreg;
    logic par_bit;
    logic pend;
    logic [urbs_pkg::ENT_W-1:0] pend_ent;
    logic dor_lat;
    logic u2x;
    logic rxcie;
    logic rxen;
    logic csz2;
    logic upm1;
    logic upm0;
    logic usbs;
    logic [1:0] csz_lo;
    logic [11:0] baud;
    logic [7:0] rdata;
    logic irq;
    logic pin_ovr;
  } urbs_rx_s;

  urbs_rx_s q;
  urbs_rx_s n;

  logic tick;
  logic maj;
  logic [4:0] spb;
  logic [4:0] vfirst;
  logic [3:0] clen;
  logic [8:0] data9;
  logic par_err;
  logic [urbs_pkg::ENT_W-1:0] stop_ent;
  logic [urbs_pkg::ENT_W-1:0] head_ent;
  logic [urbs_pkg::ENT_W-1:0] push_ent;
  logic [1:0] fifo_cnt;
  logic [1:0] cnt_next;
  logic fifo_empty;
  logic fifo_full;
  logic push;
  logic pop;
  logic flush;
  logic [7:0] rd_val;

  // ---------------------------------------------------------------
  // Character length from size select
  // ---------------------------------------------------------------
  function automatic logic [3:0] char_len(input logic [2:0] sel);
    logic [3:0] len;
    len = 4'h8;
    case (sel)
      3'h0: len = 4'h5;
      3'h1: len = 4'h6;
      3'h2: len = 4'h7;
      3'h7: len = 4'h9;
      default: len = 4'h8;
    endcase
    return len;
  endfunction

  // ---------------------------------------------------------------
  // Receive buffer
  // ---------------------------------------------------------------
  urbs_rx_fifo u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .push(push),
    .push_ent(push_ent),
    .pop(pop),
    .flush(flush),
    .head_ent(head_ent),
    .count(fifo_cnt)
  );

  // Buffer status and frame decode helpers
  assign fifo_empty = (fifo_cnt == 2'h0);
  assign fifo_full = (fifo_cnt == 2'h2);
  assign spb = q.u2x ? urbs_pkg::SPB_DBL : urbs_pkg::SPB_NORM;
  assign vfirst = q.u2x ? urbs_pkg::VOTE_DBL : urbs_pkg::VOTE_NORM;
  assign clen = char_len({q.csz2, q.csz_lo});
  // Third centre sample is the live synchronised level
  assign maj = (q.vote_a & q.vote_b) | (q.vote_a & q.sync2) |
               (q.vote_b & q.sync2);
  // Bits enter at the top, so short characters land masked low
  assign data9 = q.shreg >> (4'h9 - clen);
  assign par_err = q.upm1 & ((^data9 ^ q.par_bit) != q.upm0);
  assign stop_ent = {par_err, q.dor_lat, ~maj, data9};

  // ---------------------------------------------------------------
  // Read data mux
  // ---------------------------------------------------------------
  // Status shows the oldest unread character
  always_comb begin
    rd_val = 8'h00;
    case (reg_addr)
      urbs_pkg::ADDR_DATA: begin
        rd_val = fifo_empty ? 8'h00 : head_ent[7:0];
      end
      urbs_pkg::ADDR_STAT_A: begin
        rd_val[urbs_pkg::A_RXC] = ~fifo_empty;
        rd_val[urbs_pkg::A_FE] = ~fifo_empty & head_ent[urbs_pkg::ENT_FE];
        rd_val[urbs_pkg::A_DOR] = ~fifo_empty & head_ent[urbs_pkg::ENT_DOR];
        rd_val[urbs_pkg::A_UPE] = ~fifo_empty & q.upm1 &
                                  head_ent[urbs_pkg::ENT_PE];
        rd_val[urbs_pkg::A_U2X] = q.u2x;
      end
      urbs_pkg::ADDR_STAT_B: begin
        rd_val[urbs_pkg::B_RXCIE] = q.rxcie;
        rd_val[urbs_pkg::B_RXEN] = q.rxen;
        rd_val[urbs_pkg::B_CSZ2] = q.csz2;
        rd_val[urbs_pkg::B_RXB8] = ~fifo_empty & head_ent[8];
      end
      urbs_pkg::ADDR_STAT_C: begin
        rd_val[urbs_pkg::C_UPM1] = q.upm1;
        rd_val[urbs_pkg::C_UPM0] = q.upm0;
        rd_val[urbs_pkg::C_USBS] = q.usbs;
        rd_val[urbs_pkg::C_CSZ_LO +: 2] = q.csz_lo;
      end
      urbs_pkg::ADDR_BAUD_LO: rd_val = q.baud[7:0];
      urbs_pkg::ADDR_BAUD_HI: rd_val = {4'h0, q.baud[11:8]};
      default: rd_val = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n = q;
    push = 1'b0;
    pop = 1'b0;
    flush = 1'b0;
    push_ent = stop_ent;
    tick = 1'b0;
    n.sync1 = rx_pin;
    n.sync2 = q.sync1;

    // Sample tick divider, free running
    if (q.tick_cnt >= q.baud) begin
      n.tick_cnt = 12'h000;
      tick = 1'b1;
    end else begin
      n.tick_cnt = 12'(q.tick_cnt + 12'h001);
    end

    // Sample counter wraps once per bit
    if (tick && (q.state != urbs_pkg::ST_IDLE)) begin
      n.samp = (q.samp == spb) ? urbs_pkg::SAMP_FIRST :
               5'(q.samp + 5'h01);
      if (q.samp == vfirst) begin
        n.vote_a = q.sync2;
      end
      if (q.samp == 5'(vfirst + 5'h01)) begin
        n.vote_b = q.sync2;
      end
    end

    unique case (q.state)
      urbs_pkg::ST_IDLE: begin
        if (tick && q.rxen) begin
          n.prev_rx = q.sync2;
          // Falling edge marks sample one of a new start bit
          if (q.prev_rx && !q.sync2) begin
            if (q.pend && fifo_full) begin // Full with char held: start dropped, overrun flagged
              n.dor_lat = 1'b1;
            end else begin
              n.state = urbs_pkg::ST_START;
              n.samp = urbs_pkg::SAMP_FIRST;
              n.shreg = 9'h000;
              n.bit_idx = 4'h0;
            end
          end
        end
      end
      urbs_pkg::ST_START: begin
        if (tick && (q.samp == 5'(vfirst + 5'h02)) && maj) begin
          n.state = urbs_pkg::ST_IDLE;
          n.prev_rx = q.sync2;
        end else if (tick && (q.samp == spb)) begin
          n.state = urbs_pkg::ST_DATA;
        end
      end
      urbs_pkg::ST_DATA: begin
        if (tick && (q.samp == 5'(vfirst + 5'h02))) begin
          n.shreg = {maj, q.shreg[8:1]};
        end
        if (tick && (q.samp == spb)) begin
          if (q.bit_idx == 4'(clen - 4'h1)) begin
            n.state = q.upm1 ? urbs_pkg::ST_PARITY : urbs_pkg::ST_STOP;
          end else begin
            n.bit_idx = 4'(q.bit_idx + 4'h1);
          end
        end
      end
      urbs_pkg::ST_PARITY: begin
        if (tick && (q.samp == 5'(vfirst + 5'h02))) begin
          n.par_bit = maj;
        end
        if (tick && (q.samp == spb)) begin
          n.state = urbs_pkg::ST_STOP;
        end
      end
      urbs_pkg::ST_STOP: begin
        // Later stop bits are never looked at
        if (tick && (q.samp == 5'(vfirst + 5'h02))) begin
          n.state = urbs_pkg::ST_IDLE;
          n.prev_rx = maj;
          if (fifo_full) begin
            n.pend = 1'b1;
            n.pend_ent = stop_ent;
          end else begin
            push = 1'b1;
            n.dor_lat = 1'b0;
          end
        end
      end
    endcase

    // Held character moves in as soon as a slot frees
    if (q.pend && !fifo_full) begin
      push = 1'b1;
      push_ent = q.pend_ent;
      push_ent[urbs_pkg::ENT_DOR] = q.pend_ent[urbs_pkg::ENT_DOR] |
                                    q.dor_lat;
      n.pend = 1'b0;
      n.dor_lat = 1'b0;
    end

    // Register writes; error flags have no write path
    if (reg_wr) begin
      case (reg_addr)
        urbs_pkg::ADDR_STAT_A: begin
          n.u2x = reg_wdata[urbs_pkg::A_U2X];
        end
        urbs_pkg::ADDR_STAT_B: begin
          n.rxcie = reg_wdata[urbs_pkg::B_RXCIE];
          n.rxen = reg_wdata[urbs_pkg::B_RXEN];
          n.csz2 = reg_wdata[urbs_pkg::B_CSZ2];
        end
        urbs_pkg::ADDR_STAT_C: begin
          n.upm1 = reg_wdata[urbs_pkg::C_UPM1];
          n.upm0 = reg_wdata[urbs_pkg::C_UPM0];
          n.usbs = reg_wdata[urbs_pkg::C_USBS];
          n.csz_lo = reg_wdata[urbs_pkg::C_CSZ_LO +: 2];
        end
        urbs_pkg::ADDR_BAUD_LO: n.baud[7:0] = reg_wdata;
        urbs_pkg::ADDR_BAUD_HI: n.baud[11:8] = reg_wdata[3:0];
        default: n.baud = q.baud;
      endcase
    end

    // Read data stands for one cycle only
    n.rdata = reg_rd ? rd_val : 8'h00;
    if (reg_rd && (reg_addr == urbs_pkg::ADDR_DATA) && !fifo_empty) begin
      pop = 1'b1;
    end

    // Disable is immediate: frame, held character and buffer dropped
    if (!n.rxen) begin
      n.state = urbs_pkg::ST_IDLE;
      n.pend = 1'b0;
      n.dor_lat = 1'b0;
      n.prev_rx = 1'b0;
      push = 1'b0;
      flush = 1'b1;
    end

    // Request follows buffer occupancy, errors play no part
    if (flush) begin
      cnt_next = 2'h0;
    end else begin
      cnt_next = 2'(fifo_cnt + {1'b0, push & !fifo_full} -
                    {1'b0, pop});
    end
    n.irq = n.rxcie & (cnt_next != 2'h0);
    n.pin_ovr = n.rxen;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Line idles high, so synchronisers reset to one
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.state <= urbs_pkg::ST_IDLE;
      q.sync1 <= 1'b1;
      q.sync2 <= 1'b1;
      q.rxen <= urbs_pkg::RST_RXEN;
      q.csz2 <= urbs_pkg::RST_CSZ2;
      q.csz_lo <= urbs_pkg::RST_CSZ_LO;
      q.baud <= urbs_pkg::RST_BAUD;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = q.rdata;
  assign rx_pin_override = q.pin_ovr;
  assign rx_complete_irq = q.irq;

endmodule // urbs_receiver

/* File: tb/urbs_chk.sv */
// Purpose: Port-level checks of the serial receive buffer block
// Assumes: Register strobes are one cycle long and never together
// Notes:   Shadow bits follow software writes of the enables
`timescale 1ns/1ns
module urbs_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [urbs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Serial line
  input wire logic rx_pin,
  input wire logic rx_pin_override,
  // Request
  input wire logic rx_complete_irq
);
  logic ie_ff;
  logic en_ff;
  logic par_ff;

  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // -------------------------------------------------------------
  // Shadows of software enables
  // -------------------------------------------------------------
  // Kept here since the checker cannot see the register bodies
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ie_ff <= 1'b0;
      en_ff <= 1'b0;
      par_ff <= 1'b0;
    end else if (reg_wr && reg_addr == urbs_pkg::ADDR_STAT_B) begin
      ie_ff <= reg_wdata[urbs_pkg::B_RXCIE];
      en_ff <= reg_wdata[urbs_pkg::B_RXEN];
    end else if (reg_wr && reg_addr == urbs_pkg::ADDR_STAT_C) begin
      par_ff <= reg_wdata[urbs_pkg::C_UPM1];
    end
  end

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  AST_RDATA_IDLE: assert property (
    reg_rdata != 8'h00 |-> $past(reg_rd))
    else $error("read data outside its slot");
  AST_RXC_IRQ: assert property (
    rx_complete_irq && reg_rd && reg_addr == urbs_pkg::ADDR_STAT_A
    |=> reg_rdata[urbs_pkg::A_RXC]) else $error("flag low with request");
  AST_IRQ_HOLD: assert property (
    rx_complete_irq && ie_ff && !reg_wr
    && !(reg_rd && reg_addr == urbs_pkg::ADDR_DATA) |=> rx_complete_irq)
    else $error("request dropped while data unread");
  AST_IRQ_NEEDS_IE: assert property (
    rx_complete_irq |-> ie_ff || $past(ie_ff))
    else $error("request without enable");
  AST_OVERRIDE: assert property (
    $stable(en_ff) |-> rx_pin_override == en_ff)
    else $error("pin override differs from enable");
  AST_DISABLE_FLUSH: assert property (
    reg_wr && reg_addr == urbs_pkg::ADDR_STAT_B
    && !reg_wdata[urbs_pkg::B_RXEN] |-> ##2 !rx_complete_irq)
    else $error("request kept after disable");
  AST_CFG_READBACK: assert property (
    reg_wr && reg_addr == urbs_pkg::ADDR_STAT_C ##1
    reg_rd && reg_addr == urbs_pkg::ADDR_STAT_C
    |=> (reg_rdata & 8'h3e) == ($past(reg_wdata, 2) & 8'h3e))
    else $error("frame setup readback wrong");
  AST_PE_OFF: assert property (
    reg_rd && reg_addr == urbs_pkg::ADDR_STAT_A && !par_ff
    |=> !reg_rdata[urbs_pkg::A_UPE]) else $error("parity flag while off");

  // Main scenarios reached
  cover property ($rose(rx_complete_irq));
  cover property (reg_rd && reg_addr == urbs_pkg::ADDR_DATA
    && rx_complete_irq);
  cover property (reg_wr && reg_addr == urbs_pkg::ADDR_STAT_B
    && !reg_wdata[urbs_pkg::B_RXEN]);
endmodule // urbs_chk

bind urbs_receiver urbs_chk urbs_chk_i (
  .sys_clk(sys_clk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .rx_pin(rx_pin),
  .rx_pin_override(rx_pin_override),
  .rx_complete_irq(rx_complete_irq)
);

/* File: tb/urbs_tx_model.sv */
// Purpose: Remote serial transmitter driving the receive line
// Assumes: Bit time given in system clocks
// Notes:   Parity and stop level can be spoiled on request
`timescale 1ns/1ns
module urbs_tx_model (
  // Clock
  input wire logic sys_clk,
  // Serial line
  output logic line
);
  // Line idles high
  initial line = 1'b1;

  // One frame, least significant bit first, then one idle bit
  task automatic send(input logic [8:0] d, input int n, input bit pen,
      input bit podd, input bit bad, input bit stp, input int bt);
    logic q[$];
    logic p;
    q = {1'b0};
    p = podd ^ bad;
    for (int i = 0; i < n; i++) begin
      q.push_back(d[i]);
      p ^= d[i];
    end
    if (pen) q.push_back(p);
    q.push_back(stp);
    q.push_back(1'b1);
    // Whole bits, so every centre sample agrees
    foreach (q[i]) begin
      @(posedge sys_clk);
      line <= q[i];
      repeat (bt - 1) @(posedge sys_clk);
    end
  endtask

  // Short low spike, too brief to pass the start vote
  task automatic glitch;
    @(posedge sys_clk);
    line <= 1'b0;
    repeat (3) @(posedge sys_clk);
    line <= 1'b1;
    repeat (40) @(posedge sys_clk);
  endtask
endmodule // urbs_tx_model

/* File: tb/tb.sv */
// Purpose: Self-checking bench of the serial receive buffer block
// Assumes: Baud register left at zero, one sample per clock
// Notes:   Expected entries kept in a queue beside the design
`timescale 1ns/1ns
module tb;
  logic sys_clk;
  logic rst;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic rx_pin;
  logic rx_pin_override;
  logic rx_complete_irq;
  logic [7:0] v;
  logic [11:0] exq[$];
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int nb = 8;
  int bt = 16;
  integer seed = 32'hca30b807;
  bit pen;
  bit podd;
  bit ie;
  bit nine;
  logic [2:0] ra[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h00, 8'h06, 8'h00};

  urbs_receiver urbs_receiver_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .rx_pin(rx_pin),
    .rx_pin_override(rx_pin_override),
    .rx_complete_irq(rx_complete_irq)
  );

  urbs_tx_model tx_i (
    .sys_clk(sys_clk),
    .line(rx_pin)
  );

  // -------------------------------------------------------------
  // Clock, watchdog and verdict
  // -------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Ceiling well above the roughly 4000 cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 30000) begin
      fail_count++;
      complete_run;
    end
  end

  task automatic complete_run;
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] s, e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  // -------------------------------------------------------------
  // Register port and frame helpers
  // -------------------------------------------------------------
  task automatic bus(input logic w, r, input logic [2:0] a,
      input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, d);
  endtask

  // Data only stand in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  task automatic en(input logic [7:0] b);
    wr(urbs_pkg::ADDR_STAT_B, b);
    ie = b[7];
    nine = b[2];
  endtask

  // Write then read back at once, no gap between strobes
  task automatic cfg(input logic [7:0] c);
    bus(1'b1, 1'b0, urbs_pkg::ADDR_STAT_C, c);
    rd(urbs_pkg::ADDR_STAT_C, v);
    chk("cfg", 12'(v), 12'(c & 8'h3e));
    pen = c[5];
    podd = c[4];
    nb = nine ? 9 : 5 + int'(c[2:1]);
  endtask

  task automatic frame(input logic [8:0] d, input bit bad, stp);
    logic [8:0] m;
    m = d & 9'((1 << nb) - 1);
    tx_i.send(m, nb, pen, podd, bad, stp, bt);
    exq.push_back({pen & bad, 1'b0, ~stp, m});
  endtask

  // Status and ninth bit first, data last, since data pops
  task automatic take;
    logic [11:0] e;
    e = exq.pop_front();
    chk("irq", 12'(rx_complete_irq), 12'(ie));
    rd(urbs_pkg::ADDR_STAT_A, v);
    chk("stat", 12'({v[7], v[4:2]}), 12'({1'b1, e[9], e[10], e[11]}));
    rd(urbs_pkg::ADDR_STAT_B, v);
    chk("ninth", 12'(v[1]), 12'(e[8]));
    rd(urbs_pkg::ADDR_DATA, v);
    chk("data", 12'(v), 12'(e[7:0]));
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values, an unmapped address and an empty data read
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk("reset", 12'(v), 12'(rv[i]));
    end
    wr(urbs_pkg::ADDR_BAUD_HI, 8'hf5);
    rd(urbs_pkg::ADDR_BAUD_HI, v);
    chk("baud", 12'(v), 12'h005);
    wr(urbs_pkg::ADDR_BAUD_HI, 8'h00);
    en(8'h90);
    @(negedge sys_clk);
    chk("ovr", 12'(rx_pin_override), 12'h001);
    // Every parity mode, sizes five to eight, random errors, two stop setting
    for (int m = 0; m < 4; m++) begin
      cfg(8'({m[1], m[0], m[0], m[1:0], 1'b0}));
      repeat (2) frame(9'($random(seed)), 1'($random(seed)),
          1'($random(seed)));
      repeat (2) take;
      rd(urbs_pkg::ADDR_STAT_A, v);
      chk("empty", 12'(v[7]), 12'h000);
    end
    // Status write with zeros leaves a frame error in place
    frame(9'h0a5, 1'b0, 1'b0);
    wr(urbs_pkg::ADDR_STAT_A, 8'h00);
    take;
    // Double speed, nine bits, request masked, then a spike
    wr(urbs_pkg::ADDR_STAT_A, 8'h02);
    bt = 8;
    en(8'h14);
    cfg(8'h06);
    frame(9'($random(seed)) | 9'h100, 1'b0, 1'b1);
    take;
    tx_i.glitch;
    rd(urbs_pkg::ADDR_STAT_A, v);
    chk("spike", 12'(v[7]), 12'h000);
    wr(urbs_pkg::ADDR_STAT_A, 8'h00);
    bt = 16;
    // Overrun: two buffered, one held, start of a fourth
    en(8'h90);
    cfg(8'h06);
    repeat (3) frame(9'($random(seed)), 1'b0, 1'b1);
    exq[2][10] = 1'b1;
    tx_i.send(9'h0ff, 8, 1'b0, 1'b0, 1'b0, 1'b1, bt);
    repeat (3) take;
    frame(9'h03c, 1'b0, 1'b1);
    take;
    // Software flush: read data while the flag stands
    repeat (2) frame(9'($random(seed)), 1'b0, 1'b1);
    exq.delete();
    repeat (3) begin
      rd(urbs_pkg::ADDR_STAT_A, v);
      if (v[7]) rd(urbs_pkg::ADDR_DATA, v);
    end
    chk("drain", 12'({v, rx_complete_irq}), 12'h000);
    // Disable in mid-frame with two characters waiting
    repeat (2) frame(9'($random(seed)), 1'b0, 1'b1);
    fork
      tx_i.send(9'h155, 8, 1'b0, 1'b0, 1'b0, 1'b1, bt);
      begin
        repeat (70) @(posedge sys_clk);
        en(8'h80);
      end
    join
    exq.delete();
    rd(urbs_pkg::ADDR_STAT_A, v);
    chk("flush", 12'({v[7], rx_complete_irq, rx_pin_override}), 12'h0);
    rd(urbs_pkg::ADDR_DATA, v);
    chk("emptyrd", 12'(v), 12'h000);
    en(8'h90);
    frame(9'h0c3, 1'b0, 1'b1);
    take;
    complete_run;
  end
endmodule // tb
